// File: hdl/drs_pkg.sv
package drs_pkg;

	// Register indices on the plain port
	localparam logic [3:0] REG_MODE   = 4'h0;
	localparam logic [3:0] REG_PRIO   = 4'h1;
	localparam logic [3:0] REG_QUAL   = 4'h2;
	localparam logic [3:0] REG_SLEW   = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CTRL   = 4'h5;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int PRIO_W = 3;
	localparam int NUM_REF = 2;

	// Mode field encodings
	localparam logic [1:0] MODE_AUTO_REV   = 2'h0;
	localparam logic [1:0] MODE_AUTO_NREV  = 2'h1;
	localparam logic [1:0] MODE_MAN_FALLBK = 2'h2;
	localparam logic [1:0] MODE_MAN_HOLD   = 2'h3;

	// Mode, priority and slew register fields
	localparam int MODE_LSB     = 0;
	localparam int MANREF_BIT   = 2;
	localparam int MANPIN_BIT   = 3;
	localparam int PCANCEL_BIT  = 4;
	localparam int SLEWEN_BIT   = 5;
	localparam int ZDS_BIT      = 6;
	localparam int PRIO1_LSB    = 4;
	localparam int THRESH_LSB   = 0;
	localparam int INTERVAL_LSB = 16;
	localparam int FIELD16_W    = 16;

	localparam logic [PRIO_W-1:0] PRIO0_RST = 3'h1;
	localparam logic [PRIO_W-1:0] PRIO1_RST = 3'h2;
	localparam logic [15:0] QUAL_RST      = 16'h0064;
	localparam logic [15:0] THRESH_RST    = 16'h0010;
	localparam logic [15:0] INTERVAL_RST  = 16'h0064;
	localparam logic [15:0] PHASE_STEP    = 16'h0001;

	typedef enum logic [1:0] {
		DRS_FREERUN,
		DRS_HOLDOVER,
		DRS_LOCKED
	} drs_state_t;

	// Register bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} drs_bus_req_t;

	// Switchover transient handling shown to the loop
	typedef struct packed {
		logic        phase_cancel;
		logic        slew_active;
		logic        fastlock;
		logic        not_hitless;
		logic [15:0] phase_step;
	} drs_xfer_t;

endpackage

// File: hdl/drs_selector.sv
module drs_selector
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    nrst,
	// Register port
	input  wire drs_pkg::drs_bus_req_t   bus_req,
	output logic [drs_pkg::DATA_W-1:0]   bus_rdata,
	// Monitor flags per input, asynchronous
	input  wire logic [1:0]              mon_flag,
	// Manual choice pin, asynchronous
	input  wire logic                    man_pin,
	// Loop state inputs, asynchronous
	input  wire logic                    history_valid,
	input  wire logic                    dpll_locked,
	input  wire logic                    freq_locked,
	input  wire logic                    in_gap,
	input  wire logic                    pps_inputs,
	// Selection outputs
	output logic                         ref_sel,
	output logic                         ref_active,
	output logic                         holdover,
	output logic                         freerun,
	output drs_pkg::drs_xfer_t           xfer
);
	import drs_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]        mode_reg;
	logic [7:0]        prio_reg;
	logic [15:0]       qual_time;
	logic [31:0]       slew_reg;
	logic              soft_reset;

	wire [1:0]  sel_mode  = mode_reg[MODE_LSB +: 2];
	wire        man_auto  = ~sel_mode[1];
	wire [PRIO_W-1:0] prio0 = prio_reg[0 +: PRIO_W];
	wire [PRIO_W-1:0] prio1 = prio_reg[PRIO1_LSB +: PRIO_W];
	wire [15:0] slew_thr  = slew_reg[THRESH_LSB +: FIELD16_W];
	wire [15:0] slew_int  = slew_reg[INTERVAL_LSB +: FIELD16_W];

	wire wr_mode = bus_req.wr && bus_req.addr == REG_MODE;
	wire wr_prio = bus_req.wr && bus_req.addr == REG_PRIO;
	wire wr_qual = bus_req.wr && bus_req.addr == REG_QUAL;
	wire wr_slew = bus_req.wr && bus_req.addr == REG_SLEW;
	wire wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			mode_reg  <= 8'h00;
			prio_reg  <= {1'b0, PRIO1_RST, 1'b0, PRIO0_RST};
			qual_time <= QUAL_RST;
			slew_reg  <= {INTERVAL_RST, THRESH_RST};
		end
		else
		begin
			if (wr_mode)
				mode_reg <= bus_req.wdata[7:0];
			if (wr_prio)
				prio_reg <= bus_req.wdata[7:0];
			if (wr_qual)
				qual_time <= bus_req.wdata[15:0];
			if (wr_slew)
				slew_reg <= bus_req.wdata;
		end
	end

	// Soft reset of the selection machine; a write pulse, self clearing
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			soft_reset <= 1'b0;
		else
			soft_reset <= wr_ctrl && bus_req.wdata[0];
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int SYNC_W = 8;
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	wire [SYNC_W-1:0] async_in = {pps_inputs, in_gap, freq_locked,
		dpll_locked, history_valid, man_pin, mon_flag};

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else
		begin
			sync_a <= async_in;
			sync_b <= sync_a;
		end
	end

	wire [1:0] flag_s  = sync_b[1:0];
	wire man_pin_s     = sync_b[2];
	wire hist_s        = sync_b[3];
	wire lock_s        = sync_b[4];
	wire flock_s       = sync_b[5];
	wire gap_s         = sync_b[6];
	wire pps_s         = sync_b[7];

	// ****************************************
	// Qualification timers
	// ****************************************
	logic [15:0] qual_cnt [NUM_REF];
	logic [1:0]  ref_valid;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REF; gi++)
		begin : g_qual
			always_ff @(posedge core_clk)
			begin
				if (!nrst)
				begin
					qual_cnt[gi]  <= '0;
					ref_valid[gi] <= 1'b0;
				end
				else if (flag_s[gi])
				begin
					qual_cnt[gi]  <= '0;
					ref_valid[gi] <= 1'b0;
				end
				else if (qual_cnt[gi] >= qual_time)
					ref_valid[gi] <= 1'b1;
				else
					qual_cnt[gi] <= qual_cnt[gi] + 16'h0001;
			end
		end
	endgenerate

	// ****************************************
	// Priority decode
	// ****************************************
	// Returns {found, index}; ties go to input zero
	function automatic logic [1:0] best_ref(input logic [1:0] valid,
		input logic [PRIO_W-1:0] p0, input logic [PRIO_W-1:0] p1);
		logic ok0;
		logic ok1;
		ok0 = valid[0] && p0 != '0;
		ok1 = valid[1] && p1 != '0;
		if (ok0 && (!ok1 || p0 <= p1))
			best_ref = 2'b10;
		else if (ok1)
			best_ref = 2'b11;
		else
			best_ref = 2'b00;
	endfunction

	wire [1:0] best     = best_ref(ref_valid, prio0, prio1);
	wire best_found     = best[1];
	wire best_idx       = best[0];
	wire [PRIO_W-1:0] cur_prio = ref_sel ? prio1 : prio0;
	wire [PRIO_W-1:0] bst_prio = best_idx ? prio1 : prio0;
	// Equal priorities rank input zero first, so a tie reverts to it
	wire better_ref     = best_found && best_idx != ref_sel
		&& (bst_prio < cur_prio || cur_prio == '0
		|| (bst_prio == cur_prio && !best_idx));
	wire man_choice     = mode_reg[MANPIN_BIT] ? man_pin_s
		: mode_reg[MANREF_BIT];
	wire cur_valid      = ref_valid[ref_sel];
	wire man_valid      = ref_valid[man_choice];
	wire lost_state     = hist_s ? 1'b1 : 1'b0;

	// ****************************************
	// Selection state machine
	// ****************************************
	drs_state_t state;
	drs_state_t next_state;
	logic       next_sel;

	always_comb
	begin
		next_state = state;
		next_sel   = ref_sel;
		case (state)
			DRS_LOCKED:
			begin
				if (man_auto)
				begin
					if (!cur_valid || (sel_mode == MODE_AUTO_REV
						&& better_ref))
					begin
						if (best_found)
							next_sel = best_idx;
						else
							next_state = lost_state ? DRS_HOLDOVER
								: DRS_FREERUN;
					end
				end
				else if (man_valid)
					next_sel = man_choice;
				else if (sel_mode == MODE_MAN_FALLBK && best_found)
					next_sel = best_idx;
				else
					next_state = lost_state ? DRS_HOLDOVER
						: DRS_FREERUN;
			end
			DRS_HOLDOVER, DRS_FREERUN:
			begin
				if (!man_auto && man_valid)
				begin
					next_state = DRS_LOCKED;
					next_sel   = man_choice;
				end
				else if ((man_auto || sel_mode == MODE_MAN_FALLBK)
					&& best_found)
				begin
					next_state = DRS_LOCKED;
					next_sel   = best_idx;
				end
			end
			default:
				next_state = DRS_FREERUN;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst || soft_reset)
		begin
			state   <= DRS_FREERUN;
			ref_sel <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			ref_sel <= next_sel;
		end
	end

	// ****************************************
	// Switchover transient control
	// ****************************************
	wire switching = state == DRS_LOCKED && next_state == DRS_LOCKED
		&& next_sel != ref_sel;
	wire acquiring = state != DRS_LOCKED && next_state == DRS_LOCKED;
	wire pcancel_en = mode_reg[PCANCEL_BIT];
	wire slew_en    = mode_reg[SLEWEN_BIT];
	wire zds_en     = mode_reg[ZDS_BIT];
	logic        ever_locked;

	// Not hitless for 1-PPS with zero delay sync or before lock, or in a gap
	wire risky = (pps_s && (zds_en || !ever_locked)) || gap_s;
	wire cancel_now = switching && pcancel_en && flock_s && !risky;
	wire slew_now = slew_en && (acquiring
		|| (switching && !flock_s));

	logic [15:0] slew_tmr;
	logic [15:0] next_step;

	// Step is bounded by the threshold every interval
	assign next_step = slew_thr < PHASE_STEP ? slew_thr : PHASE_STEP;

	always_ff @(posedge core_clk)
	begin
		if (!nrst || soft_reset)
			ever_locked <= 1'b0;
		else if (lock_s)
			ever_locked <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			xfer     <= '0;
			slew_tmr <= '0;
		end
		else
		begin
			if (switching || acquiring)
			begin
				xfer.phase_cancel <= cancel_now;
				xfer.slew_active  <= slew_now;
				// Neither feature: offset passes at fast-lock rate
				xfer.fastlock     <= !cancel_now && !slew_now;
				xfer.not_hitless  <= risky && switching;
				slew_tmr          <= '0;
			end
			else if (xfer.slew_active)
			begin
				if (slew_tmr >= slew_int)
				begin
					slew_tmr        <= '0;
					xfer.phase_step <= next_step;
				end
				else
				begin
					slew_tmr        <= slew_tmr + 16'h0001;
					xfer.phase_step <= '0;
				end
				// Slew ends once the loop reports lock again
				if (lock_s)
					xfer.slew_active <= 1'b0;
			end
		end
	end

	// ****************************************
	// Status and read port
	// ****************************************
	// Gapped inputs need no selection logic here: monitors are set to ride gaps; a gap marks a switch not hitless and blocks phase cancel
	wire [DATA_W-1:0] status_word = {24'h000000, ever_locked, risky,
		ref_valid, freerun, holdover, ref_active, ref_sel};
	wire [DATA_W-1:0] rd_mux =
		bus_req.addr == REG_MODE   ? {24'h000000, mode_reg} :
		bus_req.addr == REG_PRIO   ? {24'h000000, prio_reg} :
		bus_req.addr == REG_QUAL   ? {16'h0000, qual_time} :
		bus_req.addr == REG_SLEW   ? slew_reg :
		bus_req.addr == REG_STATUS ? status_word : '0;

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			bus_rdata  <= '0;
			ref_active <= 1'b0;
			holdover   <= 1'b0;
			freerun    <= 1'b1;
		end
		else if (soft_reset)
		begin
			// Pins follow the machine back to free-run
			bus_rdata  <= bus_req.rd ? rd_mux : '0;
			ref_active <= 1'b0;
			holdover   <= 1'b0;
			freerun    <= 1'b1;
		end
		else
		begin
			bus_rdata  <= bus_req.rd ? rd_mux : '0;
			ref_active <= next_state == DRS_LOCKED;
			holdover   <= next_state == DRS_HOLDOVER;
			freerun    <= next_state == DRS_FREERUN;
		end
	end

endmodule

// File: tb/drs_selector_asserts.sv
module drs_selector_asserts
(
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  nrst,
	// Register port
	input wire drs_pkg::drs_bus_req_t bus_req,
	input wire logic [31:0]           bus_rdata,
	// Inputs seen
	input wire logic [1:0]            mon_flag,
	input wire logic                  history_valid,
	// Selection outputs
	input wire logic                  ref_sel,
	input wire logic                  ref_active,
	input wire logic                  holdover,
	input wire logic                  freerun,
	input wire drs_pkg::drs_xfer_t    xfer
);
	import drs_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	rst_vals_a: assert property (disable iff (1'b0) !nrst |=>
		freerun && !ref_active && !holdover && !ref_sel && xfer == '0
		&& bus_rdata == '0) else $error("reset values wrong");
	one_state_a: assert property ($onehot({ref_active, holdover, freerun}))
		else $error("state levels not exclusive");
	rd_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
		else $error("read data outside read slot");
	stat_rd_a: assert property ($past(bus_req.rd)
		&& $past(bus_req.addr) == REG_STATUS |-> bus_rdata[3:0] ==
		{$past(freerun), $past(holdover), $past(ref_active), $past(ref_sel)})
		else $error("status differs from pins");
	no_valid_a: assert property (mon_flag == 2'b11 [*8] |-> !ref_active)
		else $error("locked with no valid input");
	hold_hist_a: assert property ($rose(holdover) |-> $past(history_valid))
		else $error("holdover without history");
	soft_rst_a: assert property (bus_req.wr && bus_req.addr == REG_CTRL
		&& bus_req.wdata[0] |-> ##[1:2] freerun)
		else $error("soft reset ignored");
	xfer_mode_a: assert property (!(xfer.fastlock
		&& (xfer.slew_active || xfer.phase_cancel)))
		else $error("fast-lock with hitless active");
endmodule

bind drs_selector drs_selector_asserts drs_selector_asserts_i (
	.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .mon_flag(mon_flag),
	.history_valid(history_valid), .ref_sel(ref_sel),
	.ref_active(ref_active), .holdover(holdover), .freerun(freerun),
	.xfer(xfer));

// File: tb/drs_ref_model.sv
module drs_ref_model
(
	// Clock
	input wire logic        core_clk,
	// Fault command from the bench, active level from the selector
	input wire logic [1:0]  fault,
	input wire logic        active,
	// Toward the selector
	output logic [1:0]      mon_flag,
	output logic            dpll_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] lock_cnt = 4'h0;
	initial mon_flag = 2'b11;
	// One summed flag per input, so only one detector kind ever reports
	always @(posedge core_clk)
		mon_flag <= fault;
	// Loop needs a while after a reference is taken before it reports lock
	always @(posedge core_clk)
		lock_cnt <= active ? lock_cnt + {3'h0, lock_cnt != 4'hF} : 4'h0;
	assign dpll_locked = (lock_cnt == 4'hF);
endmodule

// File: tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import drs_pkg::*;
	typedef struct packed
	{
		logic [3:0]  a;
		logic [31:0] d;
		logic [31:0] m;
	} drs_exp_t;
	logic          core_clk;
	logic          nrst;
	drs_bus_req_t  bus_req;
	logic [31:0]   bus_rdata;
	logic [1:0]    fault;
	logic [1:0]    mon_flag;
	logic          man_pin;
	logic          history_valid;
	logic          dpll_locked;
	logic          freq_locked;
	logic          ref_sel;
	logic          ref_active;
	logic          holdover;
	logic          freerun;
	drs_xfer_t     xfer;
	drs_exp_t      exp_q[$];
	drs_exp_t      e;
	logic          rd_d;
	logic [2:0]    p;
	int            r;
	int            n_fail = 0;
	int            check_count = 0;

	drs_selector drs_selector_i (.core_clk(core_clk), .nrst(nrst),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .mon_flag(mon_flag),
		.man_pin(man_pin), .history_valid(history_valid),
		.dpll_locked(dpll_locked), .freq_locked(freq_locked),
		.in_gap(1'b0), .pps_inputs(1'b0), .ref_sel(ref_sel),
		.ref_active(ref_active), .holdover(holdover), .freerun(freerun),
		.xfer(xfer));
	drs_ref_model drs_ref_model_i (.core_clk(core_clk), .fault(fault),
		.active(ref_active), .mon_flag(mon_flag), .dpll_locked(dpll_locked));

	// ****************************************
	// Bus tasks and comparison
	// ****************************************
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		bus_req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] m);
		@(posedge core_clk);
		exp_q.push_back('{a, d, m});
		bus_req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge core_clk);
		bus_req <= '0;
	endtask
	// Bounded wait for a state, then confirm it through the status register
	task automatic st(input logic [3:0] s, input logic [3:0] m);
		int i;
		for (i = 0; i < 80 && (({freerun, holdover, ref_active, ref_sel}
			& m) !== (s & m)); i++)
			@(posedge core_clk) #1;
		rd(REG_STATUS, {28'h0, s}, {28'h0, m});
	endtask
	task automatic check(input logic [3:0] a, input logic [31:0] x,
		input logic [31:0] g, input logic [31:0] m);
		check_count++;
		if ((g & m) !== (x & m))
		begin
			n_fail++;
			$display("[FAIL] reg %0h exp %h got %h", a, x & m, g & m);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		rd_d <= bus_req.rd;
		if (rd_d)
		begin
			e = exp_q.pop_front();
			check(e.a, e.d, bus_rdata, e.m);
		end
	end

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Whole run is a few hundred cycles
	initial
	begin
		#200us;
		n_fail++;
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{nrst, bus_req, fault, man_pin, rd_d} = '0;
		history_valid = 1'b1;
		void'($urandom(98));
		freq_locked = 1'($urandom_range(1, 0));
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		r = $urandom_range(15, 6);
		rd(REG_MODE, 32'h0, '1);
		rd(REG_PRIO, 32'h21, 32'h77);
		rd(REG_SLEW, 32'h00640010, '1);
		wr(4'(r), $urandom());
		rd(4'(r), 32'h0, '1);
		wr(REG_QUAL, 32'h4);
		rd(REG_QUAL, 32'h4, 32'hFFFF);
		st(4'b0010, 4'hF);
		wr(REG_PRIO, 32'h12);
		st(4'b0011, 4'hF);
		p = 3'($urandom_range(7, 1));
		wr(REG_PRIO, {25'h0, p, 1'b0, p});
		st(4'b0010, 4'hF);
		wr(REG_PRIO, {25'h0, p, 4'h0});
		st(4'b0011, 4'hF);
		wr(REG_MODE, {30'h0, MODE_AUTO_NREV});
		wr(REG_PRIO, 32'h21);
		repeat (20) @(posedge core_clk);
		rd(REG_STATUS, 32'h3, 32'hF);
		fault <= 2'b10;
		st(4'b0010, 4'hF);
		fault <= 2'b00;
		wr(REG_MODE, 32'h7);
		st(4'b0011, 4'hF);
		fault <= 2'b10;
		st(4'b0100, 4'hE);
		fault <= 2'b00;
		st(4'b0011, 4'hF);
		wr(REG_MODE, 32'hA);
		st(4'b0010, 4'hF);
		fault <= 2'b01;
		st(4'b0011, 4'hF);
		history_valid <= 1'b0;
		fault <= 2'b11;
		st(4'b1000, 4'hE);
		history_valid <= 1'b1;
		fault <= 2'b00;
		wr(REG_MODE, 32'h30);
		st(4'b0010, 4'hF);
		wr(REG_CTRL, 32'h1);
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		rd(REG_MODE, 32'h0, '1);
		repeat (4) @(posedge core_clk);
		finish_test();
	end
endmodule
